/* File: hdl/ecrg_pkg.sv */
// event combo reset generator: constants, register map and carrier types
// assumes a 100 MHz system clock and an avalon-mm master on the register side
// Behaviour
// - three slots: 7-bit code plus level bit
// - slot with code zero is ignored
// - fire only when all enabled slots match
// - key slot: level 1 means press only
// - input slot: level picks inactive or active
// - conditions must persist for selected hold time
// - polarity bit sets primary output level
// - bypass enable ORs reset pin into output
package ecrg_pkg;

  // ---------------------------------------------------------------
  // register map (indices, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam int         ECRG_AW          = 8;
  localparam logic [5:0] ECRG_IDX_SLOT_A  = 6'h29;
  localparam logic [5:0] ECRG_IDX_SLOT_B  = 6'h2a;
  localparam logic [5:0] ECRG_IDX_SLOT_C  = 6'h2b;
  localparam logic [5:0] ECRG_IDX_CFG     = 6'h2e;
  localparam logic [5:0] ECRG_IDX_STATUS  = 6'h2f;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int         ECRG_SLOTS       = 3;
  localparam int         ECRG_CODE_W      = 7;
  localparam int         ECRG_NUM_CODES   = 128;
  localparam int         ECRG_SLOT_LVL_B  = 7;
  localparam int         ECRG_CFG_POL_B   = 6;
  localparam int         ECRG_CFG_BYP_B   = 5;
  localparam int         ECRG_CFG_HOLD_LO = 2;
  localparam logic [7:0] ECRG_SLOT_RST    = 8'h00;
  localparam logic [7:0] ECRG_CFG_RST     = 8'h00;
  localparam logic [6:0] ECRG_CODE_NONE   = 7'h00;

  // ---------------------------------------------------------------
  // hold time selection and timing
  // ---------------------------------------------------------------
  localparam logic [2:0] ECRG_HOLD_IMM    = 3'h0;
  localparam logic [2:0] ECRG_HOLD_1P0    = 3'h1;
  localparam logic [2:0] ECRG_HOLD_1P5    = 3'h2;
  localparam logic [2:0] ECRG_HOLD_2P0    = 3'h3;
  localparam longint     ECRG_CLK_NS      = 10;
  localparam longint     ECRG_T1P0_MS     = 1000;
  localparam longint     ECRG_T1P5_MS     = 1500;
  localparam longint     ECRG_T2P0_MS     = 2000;
  localparam longint     ECRG_CYC_1P0     = ECRG_T1P0_MS * 1000000 / ECRG_CLK_NS;
  localparam longint     ECRG_CYC_1P5     = ECRG_T1P5_MS * 1000000 / ECRG_CLK_NS;
  localparam longint     ECRG_CYC_2P0     = ECRG_T2P0_MS * 1000000 / ECRG_CLK_NS;
  localparam int         ECRG_CNT_W       = 28;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ECRG_ST_IDLE   = 2'b00,
    ECRG_ST_TIMING = 2'b01,
    ECRG_ST_FIRED  = 2'b10
  } ecrg_hold_st_t;

  typedef struct packed {
    logic                 read;
    logic                 write;
    logic [ECRG_AW-1:0]   address;
    logic [31:0]          writedata;
    logic [3:0]           byteenable;
  } ecrg_avs_req_t;

  typedef struct packed {
    logic [ECRG_NUM_CODES-1:0] level;  // pressed or active per code
    logic [ECRG_NUM_CODES-1:0] is_key; // code names a key event
  } ecrg_events_t;

  typedef struct packed {
    logic                   slot_level_select;
    logic [ECRG_CODE_W-1:0] slot_event_code;
  } ecrg_slot_t;

endpackage

/* File: hdl/ecrg_top.sv */
// event combo reset generator: primary reset from simultaneous events
// assumes synchronous event levels and an avalon-mm master on sys_clk_in
`timescale 1ns/1ps
module ecrg_top
  import ecrg_pkg::*;
#(
  parameter longint HOLD_1P0_CYC = ECRG_CYC_1P0,
  parameter longint HOLD_1P5_CYC = ECRG_CYC_1P5,
  parameter longint HOLD_2P0_CYC = ECRG_CYC_2P0
) (
  input  wire logic          sys_clk_in,
  input  wire logic          nrst_in,
  input  wire logic          ce_in,
  input  wire ecrg_avs_req_t avs_req_in,
  output logic               avs_waitrequest_out,
  output logic [31:0]        avs_readdata_out,
  input  wire ecrg_events_t  events_in,
  input  wire logic          ext_reset_n_in,
  output logic               primary_reset_out
);

  // ---------------------------------------------------------------
  // state of the whole block
  // ---------------------------------------------------------------
  typedef struct packed {
    ecrg_slot_t [ECRG_SLOTS-1:0] slot;
    logic                        primary_reset_polarity;
    logic                        external_reset_bypass_enable;
    logic [2:0]                  reset_hold_time_select;
    ecrg_hold_st_t               hold_st;
    logic [ECRG_CNT_W-1:0]       hold_cnt;
    logic                        waitreq;
    logic [31:0]                 rdata;
    logic                        rst_out;
  } ecrg_state_t;

  ecrg_state_t s_q;
  ecrg_state_t s_d;

  localparam logic [ECRG_CNT_W-1:0] CNT_1P0 = ECRG_CNT_W'(HOLD_1P0_CYC);
  localparam logic [ECRG_CNT_W-1:0] CNT_1P5 = ECRG_CNT_W'(HOLD_1P5_CYC);
  localparam logic [ECRG_CNT_W-1:0] CNT_2P0 = ECRG_CNT_W'(HOLD_2P0_CYC);

  // ---------------------------------------------------------------
  // per-slot match
  // ---------------------------------------------------------------
  logic [ECRG_SLOTS-1:0] slot_en;
  logic [ECRG_SLOTS-1:0] slot_match;

  // one evaluator per slot
  for (genvar i = 0; i < ECRG_SLOTS; i++) begin : g_slot
    logic lvl;
    logic key;
    assign lvl = events_in.level[s_q.slot[i].slot_event_code];
    assign key = events_in.is_key[s_q.slot[i].slot_event_code];
    assign slot_en[i] = (s_q.slot[i].slot_event_code != ECRG_CODE_NONE);
    // key: press only, releases never match
    // input: level bit picks active or inactive
    assign slot_match[i] = key ? (s_q.slot[i].slot_level_select & lvl)
                               : (s_q.slot[i].slot_level_select ~^ lvl);
  end

  // ---------------------------------------------------------------
  // combination and hold target
  // ---------------------------------------------------------------
  logic                  combo;
  logic [ECRG_CNT_W-1:0] hold_tgt;

  // all enabled slots at once, none enabled never fires
  assign combo = (|slot_en) && (&(slot_match | ~slot_en));

  // hold target in cycles, reserved codes take the longest time
  always_comb begin
    unique case (s_q.reset_hold_time_select)
      ECRG_HOLD_IMM: hold_tgt = '0;
      ECRG_HOLD_1P0: hold_tgt = CNT_1P0;
      ECRG_HOLD_1P5: hold_tgt = CNT_1P5;
      default:       hold_tgt = CNT_2P0;
    endcase
  end

  // ---------------------------------------------------------------
  // register read mux
  // ---------------------------------------------------------------
  logic [5:0]  req_idx;
  logic [31:0] rd_mux;

  assign req_idx = avs_req_in.address[ECRG_AW-1:2];

  // unmapped indices read as zero
  always_comb begin
    rd_mux = '0;
    unique case (req_idx)
      ECRG_IDX_SLOT_A: rd_mux[7:0] = s_q.slot[0];
      ECRG_IDX_SLOT_B: rd_mux[7:0] = s_q.slot[1];
      ECRG_IDX_SLOT_C: rd_mux[7:0] = s_q.slot[2];
      ECRG_IDX_CFG: begin
        rd_mux[ECRG_CFG_POL_B]                    = s_q.primary_reset_polarity;
        rd_mux[ECRG_CFG_BYP_B]                    = s_q.external_reset_bypass_enable;
        rd_mux[ECRG_CFG_HOLD_LO+2:ECRG_CFG_HOLD_LO] = s_q.reset_hold_time_select;
      end
      ECRG_IDX_STATUS: begin
        rd_mux[0] = combo;
        rd_mux[1] = (s_q.hold_st == ECRG_ST_TIMING);
        rd_mux[2] = (s_q.hold_st == ECRG_ST_FIRED);
        rd_mux[3] = s_q.rst_out;
      end
      default: rd_mux = '0;
    endcase
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  logic fired_d;
  logic active_d;

  always_comb begin
    s_d      = s_q;
    fired_d  = 1'b0;
    active_d = 1'b0;

    // bus: one wait cycle, then a single ready cycle
    s_d.waitreq = 1'b1;
    if ((avs_req_in.read || avs_req_in.write) && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      if (avs_req_in.read) begin
        s_d.rdata = rd_mux;
      end
    end

    // write lands on the edge that sees waitrequest low
    if (avs_req_in.write && !s_q.waitreq && avs_req_in.byteenable[0]) begin
      unique case (req_idx)
        ECRG_IDX_SLOT_A: s_d.slot[0] = avs_req_in.writedata[7:0];
        ECRG_IDX_SLOT_B: s_d.slot[1] = avs_req_in.writedata[7:0];
        ECRG_IDX_SLOT_C: s_d.slot[2] = avs_req_in.writedata[7:0];
        ECRG_IDX_CFG: begin
          s_d.primary_reset_polarity       = avs_req_in.writedata[ECRG_CFG_POL_B];
          s_d.external_reset_bypass_enable = avs_req_in.writedata[ECRG_CFG_BYP_B];
          s_d.reset_hold_time_select       =
            avs_req_in.writedata[ECRG_CFG_HOLD_LO+2:ECRG_CFG_HOLD_LO];
        end
        default: ;
      endcase
    end

    // hold timer: combination must persist for the target
    unique case (s_q.hold_st)
      ECRG_ST_IDLE: begin
        s_d.hold_cnt = '0;
        if (combo) begin
          if (hold_tgt == '0) begin
            s_d.hold_st = ECRG_ST_FIRED;
          end else begin
            s_d.hold_st  = ECRG_ST_TIMING;
            s_d.hold_cnt = ECRG_CNT_W'(1);
          end
        end
      end
      ECRG_ST_TIMING: begin
        if (!combo) begin
          s_d.hold_st  = ECRG_ST_IDLE;
          s_d.hold_cnt = '0;
        end else if (s_q.hold_cnt >= hold_tgt) begin
          s_d.hold_st = ECRG_ST_FIRED;
        end else begin
          s_d.hold_cnt = s_q.hold_cnt + ECRG_CNT_W'(1);
        end
      end
      ECRG_ST_FIRED: begin
        if (!combo) begin
          s_d.hold_st  = ECRG_ST_IDLE;
          s_d.hold_cnt = '0;
        end
      end
      default: begin
        s_d.hold_st  = ECRG_ST_IDLE;
        s_d.hold_cnt = '0;
      end
    endcase

    // output: event path or reset pin, then polarity
    fired_d     = (s_d.hold_st == ECRG_ST_FIRED);
    active_d    = fired_d ||
                  (s_q.external_reset_bypass_enable && !ext_reset_n_in);
    s_d.rst_out = s_q.primary_reset_polarity ? active_d : !active_d;
  end

  // ---------------------------------------------------------------
  // state register, frozen while ce_in is low
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q.slot                         <= {ECRG_SLOTS{ECRG_SLOT_RST}};
      s_q.primary_reset_polarity       <= ECRG_CFG_RST[ECRG_CFG_POL_B];
      s_q.external_reset_bypass_enable <= ECRG_CFG_RST[ECRG_CFG_BYP_B];
      s_q.reset_hold_time_select       <= ECRG_CFG_RST[ECRG_CFG_HOLD_LO+2:ECRG_CFG_HOLD_LO];
      s_q.hold_st                      <= ECRG_ST_IDLE;
      s_q.hold_cnt                     <= '0;
      s_q.waitreq                      <= 1'b1;
      s_q.rdata                        <= '0;
      s_q.rst_out                      <= 1'b1; // active-low idle
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign avs_waitrequest_out = s_q.waitreq;
  assign avs_readdata_out    = s_q.rdata;
  assign primary_reset_out   = s_q.rst_out;

endmodule // ecrg_top

/* File: verif/ecrg_monitor.sv */
// checker: bus handshake and primary reset timing of ecrg_top
// assumes binding to ecrg_top; shadows registers from completed writes
`timescale 1ns/1ps
module ecrg_monitor
  import ecrg_pkg::*;
#(
  parameter longint HOLD_1P0_CYC = ECRG_CYC_1P0,
  parameter longint HOLD_1P5_CYC = ECRG_CYC_1P5,
  parameter longint HOLD_2P0_CYC = ECRG_CYC_2P0
) (
  input wire logic          sys_clk_in,
  input wire logic          nrst_in,
  input wire logic          ce_in,
  input wire ecrg_avs_req_t avs_req_in,
  input wire logic          avs_waitrequest_out,
  input wire logic [31:0]   avs_readdata_out,
  input wire ecrg_events_t  events_in,
  input wire logic          ext_reset_n_in,
  input wire logic          primary_reset_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  logic [2:0][7:0] sl_q;
  logic [7:0]      cf_q;
  longint          run_q, hc;
  logic            stl_q, cb, az, act, byp, dn;
  logic [5:0]      ix;
  function automatic logic hit(ecrg_slot_t s, ecrg_events_t e);
    return s.slot_event_code == 7'h0 || (e.is_key[s.slot_event_code] ?
      s.slot_level_select && e.level[s.slot_event_code] : e.level[s.slot_event_code] == s.slot_level_select);
  endfunction
  // decoded shadow state
  assign ix  = avs_req_in.address[7:2];
  assign dn  = avs_req_in.write && !avs_waitrequest_out && avs_req_in.byteenable[0];
  assign az  = sl_q[0][6:0] == 7'h0 && sl_q[1][6:0] == 7'h0 && sl_q[2][6:0] == 7'h0;
  assign cb  = !az && hit(sl_q[0], events_in) && hit(sl_q[1], events_in) && hit(sl_q[2], events_in);
  assign act = cf_q[6];
  assign byp = cf_q[5] && !ext_reset_n_in;
  assign hc  = cf_q[4:2] == 3'h0 ? 0 : cf_q[4:2] == 3'h1 ? HOLD_1P0_CYC :
               cf_q[4:2] == 3'h2 ? HOLD_1P5_CYC : HOLD_2P0_CYC;
  // register shadow and run length of the combination
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sl_q  <= '0;
      cf_q  <= 8'h00;
      run_q <= 0;
      stl_q <= 1'b0;
    end else if (ce_in) begin
      if (dn && ix >= 6'h29 && ix <= 6'h2b) sl_q[2'(ix[1:0] - 2'h1)] <= avs_req_in.writedata[7:0];
      if (dn && ix == 6'h2e) cf_q <= avs_req_in.writedata[7:0];
      run_q <= cb ? run_q + 1 : 0;
      stl_q <= cb && (stl_q || dn);
    end
  end
  sequence s_take; (avs_req_in.read || avs_req_in.write) && avs_waitrequest_out && ce_in; endsequence
  sequence s_rdone; avs_req_in.read && !avs_waitrequest_out; endsequence
  property p_wait_one; s_take |=> !avs_waitrequest_out; endproperty
  property p_wait_pls; !avs_waitrequest_out && ce_in |=> avs_waitrequest_out; endproperty
  property p_rd_slot; s_rdone ##0 (ix inside {[6'h29:6'h2b]}) |->
    avs_readdata_out == {24'h0, sl_q[2'(ix[1:0] - 2'h1)]}; endproperty
  property p_rd_unm; s_rdone ##0 !(ix inside {[6'h29:6'h2b], 6'h2e, 6'h2f}) |-> avs_readdata_out == 32'h0;
  endproperty
  // output flop uses the polarity held at the launching edge, so compare against that one
  property p_fire; ce_in && cb && !stl_q && run_q >= hc |=> primary_reset_out == $past(act); endproperty
  property p_quiet; ce_in && !byp && (!cb || (!stl_q && run_q < hc)) |=> primary_reset_out == !$past(act);
  endproperty
  property p_byp; ce_in && byp |=> primary_reset_out == $past(act); endproperty
  property p_azero; ce_in && az && !byp |=> primary_reset_out == !$past(act); endproperty
  a_wait_one: assert property (p_wait_one) else $error("no answer one cycle after request");
  a_wait_pls: assert property (p_wait_pls) else $error("answer longer than one cycle");
  a_rd_slot: assert property (p_rd_slot) else $error("slot read data wrong");
  a_rd_unm: assert property (p_rd_unm) else $error("unmapped read not zero");
  a_fire: assert property (p_fire) else $error("combination did not fire");
  a_quiet: assert property (p_quiet) else $error("fired without full held combination");
  a_byp: assert property (p_byp) else $error("reset pin not passed through");
  a_azero: assert property (p_azero) else $error("fired with all slots empty");
endmodule // ecrg_monitor

bind ecrg_top ecrg_monitor #(.HOLD_1P0_CYC(HOLD_1P0_CYC), .HOLD_1P5_CYC(HOLD_1P5_CYC),
  .HOLD_2P0_CYC(HOLD_2P0_CYC)) ecrg_monitor_inst (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
  .avs_req_in(avs_req_in), .avs_waitrequest_out(avs_waitrequest_out), .avs_readdata_out(avs_readdata_out),
  .events_in(events_in), .ext_reset_n_in(ext_reset_n_in), .primary_reset_out(primary_reset_out));

/* File: verif/ecrg_host.sv */
// host model: system reset input watching the primary reset line
// assumes the line is sampled on the system clock
`timescale 1ns/1ps
module ecrg_host (
  input  wire logic clk_in,
  input  wire logic line_in,
  input  wire logic pol_in,
  output logic      held_out
);
  logic [1:0] s_q;
  // two-stage synchroniser, as a host reset input would use
  always_ff @(posedge clk_in) s_q <= {s_q[0], line_in == pol_in};
  assign held_out = s_q[1];
endmodule // ecrg_host

/* File: verif/tb_event_combo_reset_generator.sv */
// bench: drives bus, events and reset pin of ecrg_top
// assumes ecrg_monitor bound in and ecrg_host on the output
`timescale 1ns/1ps
module tb_event_combo_reset_generator;
  import ecrg_pkg::*;
  logic clk = 0, rn = 0, ce = 1, ext = 1, wr, o, hd, pl = 0, ex = 0;
  logic [7:0]    rg [4];
  ecrg_avs_req_t rq = '0;
  ecrg_events_t  ev = '0;
  logic [31:0]   rd, got, v, lf = 32'd75623;
  int failures = 0, samples_checked = 0;
  always #5 clk = ~clk;
  ecrg_top #(.HOLD_1P0_CYC(10), .HOLD_1P5_CYC(15), .HOLD_2P0_CYC(20)) ecrg_top_inst (.sys_clk_in(clk),
    .nrst_in(rn), .ce_in(ce), .avs_req_in(rq), .avs_waitrequest_out(wr), .avs_readdata_out(rd),
    .events_in(ev), .ext_reset_n_in(ext), .primary_reset_out(o));
  ecrg_host ecrg_host_inst (.clk_in(clk), .line_in(o), .pol_in(pl), .held_out(hd));
  function automatic logic [31:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic int hcyc(int c);
    return c == 1 ? 10 : c == 2 ? 15 : 20;
  endfunction
  // expected primary output for hold time zero, from the written slots and config
  function automatic logic pe(ecrg_events_t e, logic x);
    logic all_ok = 1'b1;
    logic any_en = 1'b0;
    for (int j = 0; j < 3; j++) begin
      if (rg[j][6:0] != 7'h0) begin
        any_en = 1'b1;
        all_ok &= e.is_key[rg[j][6:0]] ? rg[j][7] & e.level[rg[j][6:0]] : rg[j][7] == e.level[rg[j][6:0]];
      end
    end
    return ((any_en & all_ok) | (rg[3][5] & !x)) == rg[3][6];
  endfunction
  task automatic test_done();
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(logic [31:0] g, logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int n = 0;
    rq.read <= !w; rq.write <= w; rq.address <= a; rq.writedata <= d; rq.byteenable <= 4'hf;
    do begin
      @(posedge clk);
      n++;
    end while (wr !== 1'b0 && n < 50);
    got = rd;
    if (n >= 50) begin
      failures++;
      test_done();
    end
    rq.read <= 1'b0; rq.write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic r(logic [7:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(got, e);
  endtask
  initial begin
    cyc(4); rn <= 1'b1; cyc(1);
    chk(o, 1);
    for (int i = 0; i < 3; i++) r(8'ha4 + 8'(4 * i), 32'h0);
    for (int i = 0; i < 3; i++) begin
      v = rnd(); bus(1'b1, 8'ha4 + 8'(4 * i), v);
      r(8'ha4 + 8'(4 * i), {24'h0, v[7:0]});
    end
    r(8'hc0, 32'h0);
    // key press on slot a, inactive input on slot b
    bus(1'b1, 8'hac, 0); bus(1'b1, 8'ha4, 8'h85); bus(1'b1, 8'ha8, 8'h0a);
    ev.is_key[5] <= 1'b1; ev.level[5] <= 1'b1; cyc(2);
    chk(o, 0);
    cyc(2); chk(hd, 1);
    ev.level[10] <= 1'b1; cyc(2);
    chk(o, 1);
    ev.level[10] <= 1'b0; ev.level[5] <= 1'b0; bus(1'b1, 8'ha4, 8'h05); cyc(2);
    chk(o, 1);
    bus(1'b1, 8'ha4, 8'h00); cyc(2);
    chk(o, 0);
    r(8'hbc, 32'h5);
    for (int c = 1; c < 5; c++) begin
      ev.level[10] <= 1'b1; bus(1'b1, 8'hb8, 8'(c << 2));
      ev.level[10] <= 1'b0; cyc(hcyc(c));
      chk(o, 1);
      cyc(2); chk(o, 0);
    end
    ev.level[10] <= 1'b1; bus(1'b1, 8'hb8, 8'h40); cyc(1);
    chk(o, 0);
    ev.level[10] <= 1'b0; cyc(2);
    chk(o, 1);
    bus(1'b1, 8'ha8, 0); bus(1'b1, 8'hb8, 8'h20);
    r(8'hb8, 32'h20);
    cyc(2);
    chk(o, 1);
    ext <= 1'b0; cyc(2);
    chk(o, 0);
    ext <= 1'b1; cyc(2);
    chk(o, 1);
    // random slots, events, clock enable and reset pin
    for (int i = 0; i < 4; i++) begin
      rg[i] = 8'(rnd()) & (i == 3 ? 8'h60 : 8'h87);
      bus(1'b1, i == 3 ? 8'hb8 : 8'ha4 + 8'(4 * i), {24'h0, rg[i]});
    end
    // expected output follows the inputs seen at the last enabled edge
    for (int k = 0; k < 400; k++) begin
      @(posedge clk);
      if (k > 0) chk(o, ex);
      if (ce) ex = pe(ev, ext);
      v = rnd();
      ev <= {rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()};
      ce <= v[0] | v[1]; ext <= v[2] | v[3];
    end
    // reset again mid-run: registers and output back to idle
    ce <= 1'b1; rn <= 1'b0; cyc(2);
    chk(o, 1); chk(wr, 1);
    rn <= 1'b1; cyc(1);
    r(8'hb8, 32'h0); r(8'ha4, 32'h0); chk(o, 1);
    test_done();
  end
endmodule // tb_event_combo_reset_generator
